// *** rtl/arc_result_config.sv ***
// Converter result registers, extended configuration and offset coefficient
//
// Overview of operation
// - Configuration bit 7 connects the switched ground pin to ground via resistor.
// - Configuration bit 4 enables the accumulator; clear forces it to zero.
// - Bit 3 flags current results whose magnitude reaches the threshold.
// - Bit 1 overrides channel select with internal temperature conversions while it stays set.
// - Bit 0 raises current interrupt only when count reaches the limit.
// - In count mode volt/temp keeps converting; only latest result kept.
// - Current result is held while current ready flag is set.
// - Reading current result clears flags 2:0 and flag 5.
// - Volt/temp result is held while its ready flag is set.
// - With current converter idle, reading volt/temp clears flags 2:1, 5.
// - Sixteen-bit offset coefficient, factory value at reset, writable.
// - Count returns to zero on reaching the limit and restarts.
// - Comparator uses all threshold bits unipolar, low fifteen when signed.
`timescale 1ns/1ps
module arc_result_config #(
	parameter logic [15:0] OFFSET_FACTORY = 16'h0000
) (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst,
	// Register bus
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic [31:0]      hrdata,
	output logic [1:0]       hresp,
	// Current converter
	input  wire logic        curValid,
	input  wire logic [15:0] curData,
	input  wire logic        curActive,
	input  wire logic        curReconfig,
	input  wire logic        unipolar,
	// Volt/temp converter
	input  wire logic        vtValid,
	input  wire logic [15:0] vtData,
	input  wire logic        vtIsTemp,
	input  wire logic [1:0]  vtChanSel,
	output logic [1:0]       vtChanSelEff,
	output logic             fastTempMode,
	// Pin control and interrupt
	output logic             gndSwitchEnable,
	output logic             irq
);
	import arc_pkg::*;

	// ====================================================================
	// State
	logic [7:0]  config_reg;
	logic [7:0]  config_next;
	logic [7:0]  flags_reg;
	logic [7:0]  flags_next;
	logic [15:0] curResult_reg;
	logic [15:0] curResult_next;
	logic [15:0] vtResult_reg;
	logic [15:0] vtResult_next;
	logic [15:0] offset_reg;
	logic [15:0] offset_next;
	logic [15:0] limit_reg;
	logic [15:0] limit_next;
	logic [15:0] threshold_reg;
	logic [15:0] threshold_next;
	logic [2:0]  irqStatus_reg;
	logic [2:0]  irqStatus_next;
	logic [2:0]  irqMask_reg;
	logic [2:0]  irqMask_next;
	logic        wrPend_reg;
	logic        wrPend_next;
	logic [31:0] wrAddr_reg;
	logic [31:0] wrAddr_next;
	logic [31:0] rdData_reg;
	logic [31:0] rdData_next;

	// ====================================================================
	// Combinational helpers
	logic        addrPhase;
	logic        rdAccess;
	logic        wrAccess;
	logic        vtIsTempEff;
	logic        vtHeld;
	logic [7:0]  flagSet;
	logic [7:0]  flagClr;
	logic [2:0]  irqSet;
	logic [2:0]  irqClr;
	logic [31:0] rdMux;

	arc_cur_if curLink ();

	// ====================================================================
	// Current channel post-processor
	arc_cur_proc u_cur_proc (
		.core_clk (core_clk),
		.rst      (rst),
		.cur      (curLink.proc)
	);

	assign curLink.convValid = curValid;
	assign curLink.convData  = curData;
	assign curLink.accEn     = config_reg[CFG_ACC_EN];
	assign curLink.cmpEn     = config_reg[CFG_CMP_EN];
	assign curLink.cntEn     = config_reg[CFG_CNT_EN];
	assign curLink.unipolar  = unipolar;
	assign curLink.reconfig  = curReconfig;
	assign curLink.threshold = threshold_reg;
	assign curLink.limit     = limit_reg;

	// ====================================================================
	// Bus decode
	// Zero wait states: the master idles during every data phase, so a
	// write always lands before the next address phase is sampled.
	assign addrPhase = hsel & hready & htrans[1];
	assign rdAccess  = addrPhase & !hwrite;
	assign wrAccess  = addrPhase & hwrite;

	always_comb
	begin
		rdMux = 32'h00000000;
		unique case (haddr)
			ADDR_CONFIG:      rdMux = {24'h000000, config_reg};
			ADDR_CUR_RESULT:  rdMux = {16'h0000, curResult_reg};
			ADDR_VT_RESULT:   rdMux = {16'h0000, vtResult_reg};
			ADDR_CUR_OFFSET:  rdMux = {16'h0000, offset_reg};
			ADDR_COUNT_LIMIT: rdMux = {16'h0000, limit_reg};
			ADDR_COUNT:       rdMux = {16'h0000, curLink.count};
			ADDR_THRESHOLD:   rdMux = {16'h0000, threshold_reg};
			ADDR_ACCUM:       rdMux = curLink.accum;
			ADDR_FLAGS:       rdMux = {24'h000000, flags_reg};
			ADDR_IRQ_STATUS:  rdMux = {29'h00000000, irqStatus_reg};
			ADDR_IRQ_MASK:    rdMux = {29'h00000000, irqMask_reg};
			default:          rdMux = 32'h00000000;
		endcase
	end

	// ====================================================================
	// Bus capture
	always_comb
	begin
		// Write data follow the address by a cycle, so the address is kept
		wrPend_next = wrAccess;
		wrAddr_next = wrAccess ? haddr : wrAddr_reg;
		rdData_next = rdAccess ? rdMux : rdData_reg;
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			wrPend_reg <= 1'b0;
			wrAddr_reg <= 32'h00000000;
			rdData_reg <= 32'h00000000;
		end
		else
		begin
			wrPend_reg <= wrPend_next;
			wrAddr_reg <= wrAddr_next;
			rdData_reg <= rdData_next;
		end
	end

	// ====================================================================
	// Current result
	always_comb
	begin
		curResult_next = curResult_reg;
		if (curValid && !flags_reg[FLG_CUR])
			curResult_next = curData;
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			curResult_reg <= RESULT_RST;
		end
		else
		begin
			curResult_reg <= curResult_next;
		end
	end

	// ====================================================================
	// Volt/temp result
	always_comb
	begin
		vtHeld = flags_reg[FLG_VOLT] | flags_reg[FLG_TEMP];
		vtResult_next = vtResult_reg;
		// Count mode keeps only the newest result, so hold is waived
		if (vtValid && (!vtHeld || config_reg[CFG_CNT_EN]))
			vtResult_next = vtData;
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			vtResult_reg <= RESULT_RST;
		end
		else
		begin
			vtResult_reg <= vtResult_next;
		end
	end

	// ====================================================================
	// Converter flags
	always_comb
	begin
		// Fast mode result always comes from the internal sensor
		vtIsTempEff = vtIsTemp | config_reg[CFG_FAST_TEMP];
		flagSet = 8'h00;
		flagSet[FLG_CUR]  = curValid;
		flagSet[FLG_VOLT] = vtValid & !vtIsTempEff;
		flagSet[FLG_TEMP] = vtValid & vtIsTempEff;
		flagSet[FLG_CMP]  = curLink.cmpHit;
		flagClr = 8'h00;
		if (rdAccess && haddr == ADDR_CUR_RESULT)
			flagClr = FLG_CLR_CUR;
		else if (rdAccess && haddr == ADDR_VT_RESULT && !curActive)
			flagClr = FLG_CLR_VT;
		// A new event in the clearing cycle survives
		flags_next = (flags_reg & ~flagClr) | flagSet;
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			flags_reg <= 8'h00;
		end
		else
		begin
			flags_reg <= flags_next;
		end
	end

	// ====================================================================
	// Interrupt status
	always_comb
	begin
		irqSet = IRQ_RST;
		irqSet[IRQ_CUR] = config_reg[CFG_CNT_EN] ?
			curLink.countHit : curValid;
		irqSet[IRQ_VT]  = vtValid;
		irqSet[IRQ_CMP] = curLink.cmpHit;
		irqClr = IRQ_RST;
		if (rdAccess && haddr == ADDR_IRQ_STATUS)
			irqClr = 3'h7;
		// An event in the reading cycle is not lost
		irqStatus_next = (irqStatus_reg & ~irqClr) | irqSet;
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			irqStatus_reg <= IRQ_RST;
		end
		else
		begin
			irqStatus_reg <= irqStatus_next;
		end
	end

	// ====================================================================
	// Configuration and interrupt mask
	always_comb
	begin
		config_next  = config_reg;
		irqMask_next = irqMask_reg;
		if (wrPend_reg)
		begin
			unique case (wrAddr_reg)
				// Reserved bits are stored as written
				ADDR_CONFIG:   config_next = hwdata[7:0];
				ADDR_IRQ_MASK: irqMask_next = hwdata[2:0];
				default:       config_next = config_reg;
			endcase
		end
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			config_reg  <= CONFIG_RST;
			irqMask_reg <= IRQ_RST;
		end
		else
		begin
			config_reg  <= config_next;
			irqMask_reg <= irqMask_next;
		end
	end

	// ====================================================================
	// Offset coefficient, count limit and threshold
	always_comb
	begin
		offset_next    = offset_reg;
		limit_next     = limit_reg;
		threshold_next = threshold_reg;
		if (wrPend_reg)
		begin
			unique case (wrAddr_reg)
				ADDR_CUR_OFFSET:  offset_next = hwdata[15:0];
				ADDR_COUNT_LIMIT: limit_next = hwdata[15:0];
				ADDR_THRESHOLD:   threshold_next = hwdata[15:0];
				default:          offset_next = offset_reg;
			endcase
		end
	end

	// Factory offset is a parameter so each part can carry its own
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			offset_reg    <= OFFSET_FACTORY;
			limit_reg     <= LIMIT_RST;
			threshold_reg <= THRESH_RST;
		end
		else
		begin
			offset_reg    <= offset_next;
			limit_reg     <= limit_next;
			threshold_reg <= threshold_next;
		end
	end

	// ====================================================================
	// Outputs
	assign hreadyout       = 1'b1;
	assign hresp           = HRESP_OKAY;
	assign hrdata          = rdData_reg;
	assign gndSwitchEnable = config_reg[CFG_SWITCHED_GROUND_PIN];
	assign fastTempMode    = config_reg[CFG_FAST_TEMP];
	assign vtChanSelEff    = config_reg[CFG_FAST_TEMP] ?
		INT_SENSOR_SEL : vtChanSel;
	assign irq             = |(irqStatus_reg & irqMask_reg);
endmodule // arc_result_config

// *** inc/arc_pkg.sv ***
// Register map, field positions and reset values of the converter result logic
package arc_pkg;
	// ====================================================================
	// Byte addresses on the register bus
	localparam logic [31:0] ADDR_CONFIG      = 32'hFFFF051C;
	localparam logic [31:0] ADDR_CUR_RESULT  = 32'hFFFF0520;
	localparam logic [31:0] ADDR_VT_RESULT   = 32'hFFFF0524;
	localparam logic [31:0] ADDR_CUR_OFFSET  = 32'hFFFF0530;
	localparam logic [31:0] ADDR_COUNT_LIMIT = 32'hFFFF0548;
	localparam logic [31:0] ADDR_COUNT       = 32'hFFFF054C;
	localparam logic [31:0] ADDR_THRESHOLD   = 32'hFFFF0550;
	localparam logic [31:0] ADDR_ACCUM       = 32'hFFFF055C;
	localparam logic [31:0] ADDR_FLAGS       = 32'hFFFF0560;
	localparam logic [31:0] ADDR_IRQ_STATUS  = 32'hFFFF0564;
	localparam logic [31:0] ADDR_IRQ_MASK    = 32'hFFFF0568;
	// ====================================================================
	// Extended configuration fields
	localparam int CFG_SWITCHED_GROUND_PIN    = 7;
	localparam int CFG_ACC_EN    = 4;
	localparam int CFG_CMP_EN    = 3;
	localparam int CFG_FAST_TEMP = 1;
	localparam int CFG_CNT_EN    = 0;
	// ====================================================================
	// Converter flag register fields
	localparam int FLG_CUR  = 0;
	localparam int FLG_VOLT = 1;
	localparam int FLG_TEMP = 2;
	localparam int FLG_CMP  = 5;
	localparam logic [7:0] FLG_CLR_CUR = 8'h27;
	localparam logic [7:0] FLG_CLR_VT  = 8'h26;
	// ====================================================================
	// Interrupt status and mask fields
	localparam int IRQ_CUR = 0;
	localparam int IRQ_VT  = 1;
	localparam int IRQ_CMP = 2;
	// ====================================================================
	// Reset values and codes
	localparam logic [7:0]  CONFIG_RST      = 8'h00;
	localparam logic [15:0] LIMIT_RST       = 16'h0001;
	localparam logic [15:0] THRESH_RST      = 16'h0000;
	localparam logic [15:0] RESULT_RST      = 16'h0000;
	localparam logic [2:0]  IRQ_RST         = 3'h0;
	localparam logic [1:0]  INT_SENSOR_SEL  = 2'h2;
	localparam logic [15:0] COUNT_STEP      = 16'h0001;
	localparam logic [1:0]  HRESP_OKAY      = 2'h0;
endpackage

// *** inc/arc_cur_if.sv ***
// Link between the register logic and the current channel post-processor
`timescale 1ns/1ps
interface arc_cur_if;
	logic        convValid;
	logic [15:0] convData;
	logic        accEn;
	logic        cmpEn;
	logic        cntEn;
	logic        unipolar;
	logic        reconfig;
	logic [15:0] threshold;
	logic [15:0] limit;
	logic [15:0] count;
	logic [31:0] accum;
	logic        cmpHit;
	logic        countHit;
	modport ctl (
		output convValid, convData, accEn, cmpEn, cntEn, unipolar,
		output reconfig, threshold, limit,
		input  count, accum, cmpHit, countHit
	);
	modport proc (
		input  convValid, convData, accEn, cmpEn, cntEn, unipolar,
		input  reconfig, threshold, limit,
		output count, accum, cmpHit, countHit
	);
endinterface // arc_cur_if

// *** rtl/arc_cur_proc.sv ***
// Current channel result counter, accumulator and threshold comparator
`timescale 1ns/1ps
module arc_cur_proc (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Link to register logic
	arc_cur_if.proc  cur
);
	import arc_pkg::*;

	logic [15:0] count_reg;
	logic [15:0] count_next;
	logic [31:0] accum_reg;
	logic [31:0] accum_next;
	logic [15:0] magnitude;
	logic [15:0] compareTh;
	logic [15:0] countInc;
	logic [31:0] sample;

	// ====================================================================
	// Next state
	always_comb
	begin
		magnitude = cur.convData;
		compareTh = cur.threshold;
		sample = {16'h0000, cur.convData};
		if (!cur.unipolar)
		begin
			// Top bit of the threshold is ignored for signed results
			magnitude = cur.convData[15] ?
				16'(~cur.convData + COUNT_STEP) : cur.convData;
			compareTh = {1'b0, cur.threshold[14:0]};
			sample = {{16{cur.convData[15]}}, cur.convData};
		end
		countInc = 16'(count_reg + COUNT_STEP);
		cur.cmpHit = cur.cmpEn & cur.convValid
			& (magnitude >= compareTh);
		cur.countHit = cur.cntEn & cur.convValid
			& (countInc == cur.limit);
		count_next = count_reg;
		if (cur.reconfig | !cur.cntEn)
			count_next = RESULT_RST;
		else if (cur.countHit)
			count_next = RESULT_RST;
		else if (cur.convValid)
			count_next = countInc;
		accum_next = accum_reg;
		if (cur.reconfig | !cur.accEn)
			accum_next = 32'h00000000;
		else if (cur.convValid)
			accum_next = 32'(accum_reg + sample);
		cur.count = count_reg;
		cur.accum = accum_reg;
	end

	// ====================================================================
	// Registers
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			count_reg <= RESULT_RST;
			accum_reg <= 32'h00000000;
		end
		else
		begin
			count_reg <= count_next;
			accum_reg <= accum_next;
		end
	end
endmodule // arc_cur_proc

// *** verif/arc_result_config_assertions.sv ***
// Port-level checks on the converter result logic
`timescale 1ns/1ps
module arc_result_config_assertions (
	// Clock and reset
	input wire logic        core_clk,
	input wire logic        rst,
	// Register bus
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic [31:0] hrdata,
	input wire logic [1:0]  hresp,
	// Pins
	input wire logic [1:0]  vtChanSel,
	input wire logic [1:0]  vtChanSelEff,
	input wire logic        fastTempMode,
	input wire logic        gndSwitchEnable
);
	import arc_pkg::*;
	// ====================================================================
	// Request decode
	wire rdTk = hsel && hready && htrans[1] && !hwrite;
	wire cfgWr = hsel && hready && htrans[1] && hwrite && haddr == ADDR_CONFIG;
	wire rdHole = rdTk && haddr == 32'hFFFF0570;
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// ====================================================================
	// Properties
	a_resp_okay: assert property (hresp == HRESP_OKAY && hreadyout)
		else $error("bus response not okay and ready");
	a_fast_chan: assert property (fastTempMode |-> vtChanSelEff == 2'h2)
		else $error("fast mode without sensor select");
	a_chan_pass: assert property (!fastTempMode |-> vtChanSelEff == vtChanSel)
		else $error("channel select not passed through");
	a_gnd_write: assert property (cfgWr ##1 1'b1 |=> gndSwitchEnable == $past(hwdata[7]))
		else $error("ground switch does not follow written bit");
	a_fast_write: assert property (cfgWr ##1 1'b1 |=> fastTempMode == $past(hwdata[1]))
		else $error("fast mode does not follow written bit");
	a_gnd_cause: assert property ($changed(gndSwitchEnable) |-> $past(cfgWr, 2))
		else $error("ground switch moved without write");
	a_fast_cause: assert property (!$stable(fastTempMode) |-> $past(cfgWr, 2))
		else $error("fast mode moved without write");
	a_hole_zero: assert property (rdHole |=> hrdata == 32'h00000000)
		else $error("unmapped read not zero");
	a_rd_holds: assert property (!$past(rdTk) |-> $stable(hrdata))
		else $error("read data moved without read");
endmodule // arc_result_config_assertions

bind arc_result_config arc_result_config_assertions arc_result_config_assertions_inst (
	.core_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
	.hreadyout, .hrdata, .hresp, .vtChanSel, .vtChanSelEff, .fastTempMode,
	.gndSwitchEnable
);

// *** verif/arc_result_config_tb.sv ***
// Self-checking bench for the converter result logic
`timescale 1ns/1ps
module arc_result_config_tb;
	import arc_pkg::*;
	// ====================================================================
	// Signals
	typedef struct {logic [31:0] a; logic [31:0] d; logic [31:0] e;} arc_row_t;
	localparam logic [15:0] OFF_FACT = 16'h5A3C; // Arbitrary factory value
	logic        core_clk;
	logic        rst;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic        curValid;
	logic [15:0] curData;
	logic        curActive;
	logic        curReconfig;
	logic        unipolar;
	logic        vtValid;
	logic [15:0] vtData;
	logic        vtIsTemp;
	logic [1:0]  vtChanSel;
	wire         hreadyout;
	wire  [31:0] hrdata;
	wire  [1:0]  hresp;
	wire  [1:0]  vtChanSelEff;
	wire         fastTempMode;
	wire         gndSwitchEnable;
	wire         irq;
	int          err_count = 0;
	int          samples_checked = 0;
	arc_row_t    rows [6] = '{
		'{ADDR_CUR_OFFSET, 32'h0000A5C3, 32'h0000A5C3},
		'{ADDR_THRESHOLD, 32'h00001234, 32'h00001234},
		'{ADDR_COUNT_LIMIT, 32'h00000003, 32'h00000003},
		'{ADDR_CUR_RESULT, 32'h0000FFFF, 32'h00000000},
		'{32'hFFFF0570, 32'hFFFFFFFF, 32'h00000000},
		'{ADDR_CONFIG, 32'h00000080, 32'h00000080}};
	arc_result_config #(.OFFSET_FACTORY(OFF_FACT)) arc_result_config_inst (
		.core_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hreadyout, .hrdata, .hresp, .curValid, .curData,
		.curActive, .curReconfig, .unipolar, .vtValid, .vtData, .vtIsTemp,
		.vtChanSel, .vtChanSelEff, .fastTempMode, .gndSwitchEnable, .irq);
	// ====================================================================
	// Tasks
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e)
		begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	// Zero wait states today, but the master still waits on ready
	task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge core_clk);
		hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= w;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(a, 1'b1, d, q);
		// Let the written register reach the pins before they are compared
		@(posedge core_clk);
	endtask
	task automatic rdchk(input string n, input logic [31:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(a, 1'b0, 32'h00000000, q);
		chk(n, q, e);
	endtask
	task automatic conv(input logic c, input logic [15:0] d, input logic t);
		@(posedge core_clk);
		curValid <= c; vtValid <= !c; curData <= d; vtData <= d; vtIsTemp <= t;
		@(posedge core_clk);
		curValid <= 1'b0; vtValid <= 1'b0;
		#1;
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// ====================================================================
	// Clock, watchdog and sequence
	initial
	begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	initial
	begin
		repeat (20000) @(posedge core_clk);
		err_count++;
		tally_and_finish();
	end
	initial
	begin
		rst = 1'b1; hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hsize = 3'h2;
		hwdata = 0; curValid = 0; curData = 0; curActive = 0; curReconfig = 0;
		unipolar = 1; vtValid = 0; vtData = 0; vtIsTemp = 0; vtChanSel = 2'h1;
		repeat (8) @(posedge core_clk);
		rst <= 1'b0;
		rdchk("offset rst", ADDR_CUR_OFFSET, {16'h0, OFF_FACT});
		rdchk("limit rst", ADDR_COUNT_LIMIT, {16'h0, LIMIT_RST});
		rdchk("cur rst", ADDR_CUR_RESULT, {16'h0, RESULT_RST});
		foreach (rows[i])
		begin
			wr(rows[i].a, rows[i].d);
			rdchk("row", rows[i].a, rows[i].e);
		end
		chk("gnd on", gndSwitchEnable, 1'b1);
		// Held result and read clear
		conv(1'b0, 16'h3333, 1'b1);
		conv(1'b1, 16'h1111, 1'b0);
		conv(1'b1, 16'h2222, 1'b0);
		rdchk("flags set", ADDR_FLAGS, 32'h5);
		rdchk("cur held", ADDR_CUR_RESULT, 32'h1111);
		rdchk("flags clr", ADDR_FLAGS, 32'h0);
		curActive <= 1'b1;
		conv(1'b0, 16'h4444, 1'b0);
		conv(1'b0, 16'h5555, 1'b1);
		rdchk("vt held", ADDR_VT_RESULT, 32'h4444);
		rdchk("vt no clr", ADDR_FLAGS, 32'h6);
		curActive <= 1'b0;
		rdchk("vt again", ADDR_VT_RESULT, 32'h4444);
		rdchk("vt clr", ADDR_FLAGS, 32'h0);
		// Interrupt raise, clear and mask
		wr(ADDR_IRQ_MASK, 32'h1);
		rdchk("irq st", ADDR_IRQ_STATUS, 32'h3);
		conv(1'b1, 16'h0010, 1'b0);
		chk("irq up", irq, 1'b1);
		rdchk("irq st", ADDR_IRQ_STATUS, 32'h1);
		chk("irq down", irq, 1'b0);
		wr(ADDR_IRQ_MASK, 32'h0);
		conv(1'b1, 16'h0010, 1'b0);
		chk("irq masked", irq, 1'b0);
		// Count mode with limit three
		wr(ADDR_CONFIG, 32'h1);
		chk("gnd off", gndSwitchEnable, 1'b0);
		rdchk("irq st", ADDR_IRQ_STATUS, 32'h1);
		conv(1'b1, 16'h0001, 1'b0);
		conv(1'b1, 16'h0002, 1'b0);
		rdchk("cnt quiet", ADDR_IRQ_STATUS, 32'h0);
		conv(1'b1, 16'h0003, 1'b0);
		rdchk("cnt fire", ADDR_IRQ_STATUS, 32'h1);
		rdchk("cnt wrap", ADDR_COUNT, 32'h0);
		conv(1'b0, 16'h6666, 1'b0);
		conv(1'b0, 16'h7777, 1'b0);
		rdchk("vt latest", ADDR_VT_RESULT, 32'h7777);
		// Comparator and accumulator
		wr(ADDR_THRESHOLD, 32'h0100);
		wr(ADDR_CONFIG, 32'h18);
		rdchk("cur clr", ADDR_CUR_RESULT, 32'h0010);
		rdchk("irq st", ADDR_IRQ_STATUS, 32'h2);
		conv(1'b1, 16'h00FF, 1'b0);
		rdchk("below th", ADDR_IRQ_STATUS, 32'h1);
		conv(1'b1, 16'h0100, 1'b0);
		rdchk("at th", ADDR_IRQ_STATUS, 32'h5);
		rdchk("acc sum", ADDR_ACCUM, 32'h1FF);
		rdchk("cmp flag", ADDR_FLAGS, 32'h21);
		rdchk("cur ff", ADDR_CUR_RESULT, 32'hFF);
		rdchk("cmp clr", ADDR_FLAGS, 32'h0);
		wr(ADDR_CONFIG, 32'h08);
		rdchk("acc zero", ADDR_ACCUM, 32'h0);
		unipolar <= 1'b0;
		wr(ADDR_THRESHOLD, 32'h8100);
		conv(1'b1, 16'hFF00, 1'b0);
		rdchk("signed th", ADDR_IRQ_STATUS, 32'h5);
		// Fast temperature override
		wr(ADDR_CONFIG, 32'h2);
		chk("fast sel", vtChanSelEff, 2'h2);
		wr(ADDR_CONFIG, 32'h80);
		chk("pass sel", vtChanSelEff, 2'h1);
		// Reset in mid-run
		rst <= 1'b1;
		repeat (3) @(posedge core_clk);
		rst <= 1'b0;
		rdchk("cfg rst", ADDR_CONFIG, {24'h0, CONFIG_RST});
		chk("gnd rst", gndSwitchEnable, 1'b0);
		tally_and_finish();
	end
endmodule // arc_result_config_tb
